// File: wlrc_map.svh
// Opcodes, register indices, field positions and reset values
// Assumes inclusion by bare name from the decoder and its bench
`ifndef WLRC_MAP_SVH
`define WLRC_MAP_SVH

// ****************************************
// Opcodes
// ****************************************
`define OP_SET_LATCH 8'h06
`define OP_CLR_LATCH 8'h04
`define OP_WR_STATUS 8'h01
`define OP_RD_SR1 8'h05
`define OP_RD_SR2 8'h07
`define OP_RD_CR1 8'h35
`define OP_RD_CR2 8'h3F
`define OP_RD_CR4 8'h45
`define OP_RD_CR5 8'h5E
`define OP_WR_ANY 8'h71
`define OP_RD_ANY 8'h65

// ****************************************
// Register address decode
// ****************************************
`define ADDR_VOL_PAGE 8'h07
`define ADDR_NV_PAGE 8'h00
`define ADDR_MID 8'h00
`define ADDR_LAST_BYTE 2'h2
`define IDX_SR1 3'h0
`define IDX_SR2 3'h1
`define IDX_CR1 3'h2
`define IDX_CR2 3'h3
`define IDX_CR4 3'h5
`define IDX_CR5 3'h6

// ****************************************
// Fields and defaults
// ****************************************
`define SR1_WIP_BIT 0
`define SR1_WEL_BIT 1
`define SR1_SWD_BIT 7
`define SR1_WR_MASK 8'hFC
`define SR2_CRC_SUSPEND_FLAG_BIT 0
`define SR2_CRC_ABORT_FLAG_BIT 1
`define CR5_RLC_LO_BIT 0
`define CR5_RLC_HI_BIT 1
`define SR1_DEF 8'h00
`define CR1_DEF 8'h00
`define CR2_DEF 8'h00
`define CR4_DEF 8'h00
`define CR5_DEF 8'h00
`define BITS_PER_BYTE 4'h8

`endif

// File: wlrc_pkg.sv
// Types shared by the latch and register command decoder
// Assumes the map header supplies every number
package wlrc_pkg;

    // ****************************************
    // Frame states
    // ****************************************
    typedef enum logic [5:0] {
        ST_OPCODE = 6'b00_0001,
        ST_ADDR = 6'b00_0010,
        ST_DUMMY = 6'b00_0100,
        ST_DATA_IN = 6'b00_1000,
        ST_DATA_OUT = 6'b01_0000,
        ST_IGNORE = 6'b10_0000
    } wlrc_state_e;

    // ****************************************
    // Serial pin bundle
    // ****************************************
    typedef struct packed {
        logic sclk;
        logic csN;
        logic wpN;
        logic [3:0] io;
    } wlrc_pins_s;

    typedef logic [7:0] wlrc_byte_t;

endpackage : wlrc_pkg

// File: wlrc_cmd_decoder.sv
// Latch and register command decoder of a serial memory
// Assumes serial pins arrive asynchronous to ref_clk, far slower
`timescale 1ns/1ps
`include "wlrc_map.svh"

module wlrc_cmd_decoder (
    // Clock and resets
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic swReset,
    // Serial pins
    input wire logic sclk,
    input wire logic csN,
    input wire logic wpN,
    input wire logic [3:0] ioIn,
    output logic [3:0] ioOut,
    output logic [3:0] ioOe,
    // Protocol mode
    input wire logic dualProtocolMode,
    input wire logic quadProtocolMode,
    // Embedded operation status
    input wire logic writeInProgressFlag,
    input wire logic crcSuspendFlag,
    input wire logic crcAbortFlag,
    // Register view
    output logic [7:0] statusRegOne,
    output logic writeLatchBit
);

    // ****************************************
    // Functions
    // ****************************************
    function automatic logic [3:0] addrDecode(input logic [23:0] a);
        logic pageOk;
        pageOk = (a[23:16] == `ADDR_VOL_PAGE) ||
            (a[23:16] == `ADDR_NV_PAGE);
        addrDecode = {pageOk && (a[15:8] == `ADDR_MID) &&
            (a[7:0] <= {5'h0_0, `IDX_CR5}), a[2:0]};
    endfunction : addrDecode

    function automatic logic canWrite(input logic [2:0] idx);
        canWrite = (idx == `IDX_SR1) || (idx == `IDX_CR1) ||
            (idx == `IDX_CR2) || (idx == `IDX_CR4) ||
            (idx == `IDX_CR5);
    endfunction : canWrite

    function automatic logic [7:0] wrMerge(input logic [2:0] idx,
            input logic [7:0] old, input logic [7:0] val);
        if (idx == `IDX_SR1) begin
            wrMerge = (val & `SR1_WR_MASK) | (old & ~`SR1_WR_MASK);
        end else begin
            wrMerge = val;
        end
    endfunction : wrMerge

    function automatic logic [7:0] regDefault(input logic [2:0] idx);
        case (idx)
            `IDX_SR1: regDefault = `SR1_DEF;
            `IDX_CR1: regDefault = `CR1_DEF;
            `IDX_CR2: regDefault = `CR2_DEF;
            `IDX_CR4: regDefault = `CR4_DEF;
            `IDX_CR5: regDefault = `CR5_DEF;
            default: regDefault = 8'h00;
        endcase
    endfunction : regDefault

    // ****************************************
    // Pin synchronisers and edge detection
    // ****************************************
    wlrc_pkg::wlrc_pins_s pinsRaw;
    wlrc_pkg::wlrc_pins_s syncA_q;
    wlrc_pkg::wlrc_pins_s syncB_q;
    wlrc_pkg::wlrc_pins_s last_q;
    logic sclkRise;
    logic sclkFall;
    logic csRise;
    logic csFall;

    // Idle levels after reset, so no false clock edge opens a frame
    localparam wlrc_pkg::wlrc_pins_s pinsIdle = '{sclk: 1'b0, csN: 1'b1,
        wpN: 1'b1, io: 4'h0};

    assign pinsRaw = {sclk, csN, wpN, ioIn};

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            syncA_q <= pinsIdle;
            syncB_q <= pinsIdle;
            last_q <= pinsIdle;
        end else begin
            syncA_q <= pinsRaw;
            syncB_q <= syncA_q;
            last_q <= syncB_q;
        end
    end

    // Clock edges only count inside a frame
    assign sclkRise = syncB_q.sclk & ~last_q.sclk & ~syncB_q.csN;
    assign sclkFall = ~syncB_q.sclk & last_q.sclk & ~syncB_q.csN;
    assign csRise = syncB_q.csN & ~last_q.csN;
    assign csFall = ~syncB_q.csN & last_q.csN;

    // ****************************************
    // Register storage
    // ****************************************
    logic [7:0] vol_q [0:6];
    logic [7:0] vol_d [0:6];
    logic [7:0] nv_q [0:6];
    logic [7:0] nv_d [0:6];
    logic [7:0] sr1View;
    logic [7:0] sr2View;
    logic [1:0] rlc;
    logic locked;

    always_comb begin
        sr1View = vol_q[`IDX_SR1];
        sr1View[`SR1_WIP_BIT] = writeInProgressFlag;
        // Flags are live; meaningless while busy, host must wait
        sr2View = 8'h00;
        sr2View[`SR2_CRC_SUSPEND_FLAG_BIT] = crcSuspendFlag;
        sr2View[`SR2_CRC_ABORT_FLAG_BIT] = crcAbortFlag;
    end

    assign rlc = {vol_q[`IDX_CR5][`CR5_RLC_HI_BIT],
        vol_q[`IDX_CR5][`CR5_RLC_LO_BIT]};
    assign locked = vol_q[`IDX_SR1][`SR1_SWD_BIT] &
        ~syncB_q.wpN;

    function automatic logic [7:0] regRead(input logic [2:0] idx,
            input logic ok, input logic [7:0] s1,
            input logic [7:0] s2, input logic [7:0] c1,
            input logic [7:0] c2, input logic [7:0] c4,
            input logic [7:0] c5);
        regRead = 8'h00;
        if (ok) begin
            case (idx)
                `IDX_SR1: regRead = s1;
                `IDX_SR2: regRead = s2;
                `IDX_CR1: regRead = c1;
                `IDX_CR2: regRead = c2;
                `IDX_CR4: regRead = c4;
                `IDX_CR5: regRead = c5;
                default: regRead = 8'h00;
            endcase
        end
    endfunction : regRead

    // ****************************************
    // Frame state
    // ****************************************
    wlrc_pkg::wlrc_state_e state_q;
    wlrc_pkg::wlrc_state_e state_d;
    logic [7:0] shift_q, shift_d, shN;
    logic [3:0] bitCnt_q, bitCnt_d, laneW;
    logic [1:0] byteCnt_q, byteCnt_d;
    logic [1:0] dumCnt_q, dumCnt_d;
    logic [7:0] opcode_q, opcode_d;
    logic opDone_q, opDone_d;
    logic [23:0] addr_q, addr_d, addrNew;
    logic [7:0] dataByte_q, dataByte_d;
    logic dataDone_q, dataDone_d;
    logic [2:0] rdIdx_q, rdIdx_d, selIdx;
    logic rdOk_q, rdOk_d, selOk;
    logic [7:0] outSh_q, outSh_d;
    logic [3:0] ioOut_q, ioOut_d;
    logic [3:0] ioOe_q, ioOe_d;
    logic goRead;
    logic loadOut;
    logic byteEnd;

    // Only single data rate; quad wins if both modes are set
    assign laneW = quadProtocolMode ? 4'h4 :
        (dualProtocolMode ? 4'h2 : 4'h1);
    assign shN = quadProtocolMode ? {shift_q[3:0], syncB_q.io} :
        (dualProtocolMode ? {shift_q[5:0], syncB_q.io[1:0]} :
        {shift_q[6:0], syncB_q.io[0]});
    assign byteEnd = sclkRise &&
        ((bitCnt_q + laneW) == `BITS_PER_BYTE);
    assign addrNew = {addr_q[15:0], shN};

    always_comb begin
        state_d = state_q;
        shift_d = shift_q;
        bitCnt_d = bitCnt_q;
        byteCnt_d = byteCnt_q;
        dumCnt_d = dumCnt_q;
        opcode_d = opcode_q;
        opDone_d = opDone_q;
        addr_d = addr_q;
        dataByte_d = dataByte_q;
        dataDone_d = dataDone_q;
        rdIdx_d = rdIdx_q;
        rdOk_d = rdOk_q;
        outSh_d = outSh_q;
        ioOut_d = ioOut_q;
        ioOe_d = ioOe_q;
        selIdx = rdIdx_q;
        selOk = rdOk_q;
        goRead = 1'b0;
        loadOut = 1'b0;
        if (csFall) begin
            state_d = wlrc_pkg::ST_OPCODE;
            bitCnt_d = 4'h0;
            byteCnt_d = 2'h0;
            dumCnt_d = 2'h0;
            opDone_d = 1'b0;
            dataDone_d = 1'b0;
            ioOe_d = 4'h0;
        end else if (syncB_q.csN) begin
            ioOe_d = 4'h0;
        end else if (sclkRise) begin
            bitCnt_d = byteEnd ? 4'h0 : bitCnt_q + laneW;
            shift_d = shN;
            unique case (state_q)
                wlrc_pkg::ST_OPCODE: begin
                    if (byteEnd) begin
                        opcode_d = shN;
                        opDone_d = 1'b1;
                        // Latch opcodes: any further clocks ignored
                        state_d = wlrc_pkg::ST_IGNORE;
                        selOk = 1'b1;
                        case (shN)
                            `OP_WR_STATUS: begin
                                state_d = wlrc_pkg::ST_DATA_IN;
                            end
                            `OP_WR_ANY, `OP_RD_ANY: begin
                                state_d = wlrc_pkg::ST_ADDR;
                            end
                            `OP_RD_SR1: begin
                                selIdx = `IDX_SR1;
                                goRead = 1'b1;
                            end
                            `OP_RD_SR2: begin
                                selIdx = `IDX_SR2;
                                goRead = 1'b1;
                            end
                            `OP_RD_CR1: begin
                                selIdx = `IDX_CR1;
                                goRead = 1'b1;
                            end
                            `OP_RD_CR2: begin
                                selIdx = `IDX_CR2;
                                goRead = 1'b1;
                            end
                            `OP_RD_CR4: begin
                                selIdx = `IDX_CR4;
                                goRead = 1'b1;
                            end
                            `OP_RD_CR5: begin
                                selIdx = `IDX_CR5;
                                goRead = 1'b1;
                            end
                            default: begin
                            end
                        endcase
                    end
                end
                wlrc_pkg::ST_ADDR: begin
                    if (byteEnd) begin
                        addr_d = addrNew;
                        byteCnt_d = byteCnt_q + 2'h1;
                        if (byteCnt_q == `ADDR_LAST_BYTE) begin
                            if (opcode_q == `OP_WR_ANY) begin
                                state_d = wlrc_pkg::ST_DATA_IN;
                            end else begin
                                {selOk, selIdx} = addrDecode(addrNew);
                                goRead = 1'b1;
                            end
                        end
                    end
                end
                wlrc_pkg::ST_DATA_IN: begin
                    // Only the first byte counts; later ones dropped
                    if (byteEnd && !dataDone_q) begin
                        dataByte_d = shN;
                        dataDone_d = 1'b1;
                    end
                end
                wlrc_pkg::ST_DUMMY: begin
                    bitCnt_d = 4'h0;
                    dumCnt_d = dumCnt_q + 2'h1;
                    if ((dumCnt_q + 2'h1) == rlc) begin
                        state_d = wlrc_pkg::ST_DATA_OUT;
                        loadOut = 1'b1;
                    end
                end
                wlrc_pkg::ST_DATA_OUT: begin
                    loadOut = byteEnd;
                end
                wlrc_pkg::ST_IGNORE: begin
                end
            endcase
            if (goRead) begin
                rdIdx_d = selIdx;
                rdOk_d = selOk;
                dumCnt_d = 2'h0;
                if (rlc == 2'h0) begin
                    state_d = wlrc_pkg::ST_DATA_OUT;
                    loadOut = 1'b1;
                end else begin
                    state_d = wlrc_pkg::ST_DUMMY;
                end
            end
            // Reading past the byte repeats the same register
            if (loadOut) begin
                outSh_d = regRead(selIdx, selOk, sr1View, sr2View,
                    vol_q[`IDX_CR1], vol_q[`IDX_CR2],
                    vol_q[`IDX_CR4], vol_q[`IDX_CR5]);
            end
        end else if (sclkFall &&
                state_q == wlrc_pkg::ST_DATA_OUT) begin
            if (quadProtocolMode) begin
                ioOut_d = outSh_q[7:4];
                ioOe_d = 4'hF;
                outSh_d = {outSh_q[3:0], 4'h0};
            end else if (dualProtocolMode) begin
                ioOut_d = {2'h0, outSh_q[7:6]};
                ioOe_d = 4'h3;
                outSh_d = {outSh_q[5:0], 2'h0};
            end else begin
                ioOut_d = {2'h0, outSh_q[7], 1'b0};
                ioOe_d = 4'h2;
                outSh_d = {outSh_q[6:0], 1'b0};
            end
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= wlrc_pkg::ST_IGNORE;
            shift_q <= 8'h00;
            bitCnt_q <= 4'h0;
            byteCnt_q <= 2'h0;
            dumCnt_q <= 2'h0;
            opcode_q <= 8'h00;
            opDone_q <= 1'b0;
            addr_q <= 24'h00_0000;
            dataByte_q <= 8'h00;
            dataDone_q <= 1'b0;
            rdIdx_q <= 3'h0;
            rdOk_q <= 1'b0;
            outSh_q <= 8'h00;
            ioOut_q <= 4'h0;
            ioOe_q <= 4'h0;
        end else begin
            state_q <= state_d;
            shift_q <= shift_d;
            bitCnt_q <= bitCnt_d;
            byteCnt_q <= byteCnt_d;
            dumCnt_q <= dumCnt_d;
            opcode_q <= opcode_d;
            opDone_q <= opDone_d;
            addr_q <= addr_d;
            dataByte_q <= dataByte_d;
            dataDone_q <= dataDone_d;
            rdIdx_q <= rdIdx_d;
            rdOk_q <= rdOk_d;
            outSh_q <= outSh_d;
            ioOut_q <= ioOut_d;
            ioOe_q <= ioOe_d;
        end
    end

    // ****************************************
    // Register update at frame end and on soft reset
    // ****************************************
    logic [3:0] wrHit;
    logic writeOk;

    assign wrHit = addrDecode(addr_q);
    assign writeOk = dataDone_q && !locked &&
        vol_q[`IDX_SR1][`SR1_WEL_BIT];

    always_comb begin
        vol_d = vol_q;
        nv_d = nv_q;
        if (swReset) begin
            // Reset event reloads volatile copies from stored values
            vol_d = nv_q;
            vol_d[`IDX_SR1][`SR1_WEL_BIT] = 1'b0;
        end else if (csRise && opDone_q) begin
            case (opcode_q)
                `OP_SET_LATCH: begin
                    vol_d[`IDX_SR1][`SR1_WEL_BIT] = 1'b1;
                end
                `OP_CLR_LATCH: begin
                    if (!writeInProgressFlag) begin
                        vol_d[`IDX_SR1][`SR1_WEL_BIT] = 1'b0;
                    end
                end
                `OP_WR_STATUS: begin
                    if (writeOk) begin
                        vol_d[`IDX_SR1] = wrMerge(`IDX_SR1,
                            vol_q[`IDX_SR1], dataByte_q);
                        nv_d[`IDX_SR1] = wrMerge(`IDX_SR1,
                            nv_q[`IDX_SR1], dataByte_q);
                    end
                    vol_d[`IDX_SR1][`SR1_WEL_BIT] = 1'b0;
                end
                `OP_WR_ANY: begin
                    if (writeOk && wrHit[3] && canWrite(wrHit[2:0])) begin
                        vol_d[wrHit[2:0]] = wrMerge(wrHit[2:0],
                            vol_q[wrHit[2:0]], dataByte_q);
                        if (addr_q[23:16] == `ADDR_NV_PAGE) begin
                            nv_d[wrHit[2:0]] = wrMerge(wrHit[2:0],
                                nv_q[wrHit[2:0]], dataByte_q);
                        end
                    end
                    vol_d[`IDX_SR1][`SR1_WEL_BIT] = 1'b0;
                end
                default: begin
                end
            endcase
        end
    end

    // Power-on reset stands in for factory values of both copies
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < 7; i++) begin
                vol_q[i] <= regDefault(3'(i));
                nv_q[i] <= regDefault(3'(i));
            end
        end else begin
            vol_q <= vol_d;
            nv_q <= nv_d;
        end
    end

    assign ioOut = ioOut_q;
    assign ioOe = ioOe_q;
    assign statusRegOne = vol_q[`IDX_SR1];
    assign writeLatchBit = vol_q[`IDX_SR1][`SR1_WEL_BIT];

endmodule : wlrc_cmd_decoder

// File: wlrc_cmd_decoder_asserts.sv
// Port checker for the latch and register command decoder
// Assumes one clock domain and bind onto the decoder top
`timescale 1ns/1ps

module wlrc_cmd_decoder_asserts (
    // Clock and resets
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic swReset,
    // Serial pins and modes
    input wire logic sclk,
    input wire logic csN,
    input wire logic [3:0] ioOut,
    input wire logic [3:0] ioOe,
    input wire logic dualProtocolMode,
    input wire logic quadProtocolMode,
    // Register view
    input wire logic [7:0] statusRegOne,
    input wire logic writeLatchBit
);
    // ****
    // Properties
    // ****
    default clocking dcb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    reset_vals_a: assert property ($rose(arst_n) |->
        statusRegOne == 8'h00 && !writeLatchBit)
        else $error("register view not cleared after reset");
    // Pins pass a two-stage sync, so csN is seen high for a while first
    wel_frame_end_a: assert property ($changed(writeLatchBit)
        |-> $past(swReset) || (csN && $past(csN, 2)))
        else $error("write latch moved inside a frame");
    sr1_frame_end_a: assert property ($changed(statusRegOne) |->
        $past(swReset) || (csN && $past(csN, 2)))
        else $error("status one moved inside a frame");
    sr1_wip_zero_a: assert property (statusRegOne[0] == 1'b0)
        else $error("busy bit stored in status one");
    swrst_wel_a: assert property ($past(swReset) |-> !writeLatchBit)
        else $error("write latch survived soft reset");
    oe_idle_a: assert property (csN [*5] |-> ioOe == 4'h0)
        else $error("pins driven while deselected");
    oe_lanes_a: assert property (ioOe != 4'h0 |-> ioOe ==
        (quadProtocolMode ? 4'hF : dualProtocolMode ? 4'h3 : 4'h2))
        else $error("output lanes do not match mode");
    out_on_fall_a: assert property (
        $changed(ioOut) && ioOe != 4'h0 |-> !$past(sclk))
        else $error("read data moved while clock high");

    cover property ($rose(writeLatchBit));
    cover property ($fell(writeLatchBit));
    cover property (ioOe == 4'hF);
endmodule : wlrc_cmd_decoder_asserts

bind wlrc_cmd_decoder wlrc_cmd_decoder_asserts i_chk (
    .ref_clk(ref_clk), .arst_n(arst_n), .swReset(swReset),
    .sclk(sclk), .csN(csN), .ioOut(ioOut), .ioOe(ioOe),
    .dualProtocolMode(dualProtocolMode),
    .quadProtocolMode(quadProtocolMode),
    .statusRegOne(statusRegOne), .writeLatchBit(writeLatchBit)
);

// File: wlrc_host_model.sv
// Serial host that frames commands toward the decoder
// Assumes a 4 ns ref_clk; link clock idles low, 32 ns period
`timescale 1ns/1ps

module wlrc_host_model (
    // Clock
    input wire logic ref_clk,
    // Link pins
    output logic sclk,
    output logic csN,
    output logic [3:0] hostIo,
    input wire logic [3:0] pinIo
);
    int lanes;
    logic [7:0] rxByte;

    initial begin
        lanes = 1;
        sclk = 1'b0;
        csN = 1'b1;
        hostIo = 4'h0;
    end

    task automatic half();
        repeat (4) @(posedge ref_clk);
    endtask : half

    // ****
    // One frame: opcode and header, dummies, read data
    // ****
    task automatic frame(input logic [47:0] tx, input int nTx,
        input int nDum, input int nRx);
        logic [3:0] m;
        m = 4'((1 << lanes) - 1);
        rxByte = 8'h00;
        csN <= 1'b0;
        for (int i = 0; i < nTx / lanes; i++) begin
            hostIo <= (tx[47 -: 4] >> (4 - lanes)) & m | ~hostIo & ~m;
            tx = tx << lanes;
            half();
            sclk <= 1'b1;
            half();
            sclk <= 1'b0;
        end
        // Released lines toggle so a stale level never looks valid
        for (int i = 0; i < nDum + nRx / lanes; i++) begin
            hostIo <= ~hostIo;
            half();
            sclk <= 1'b1;
            if (i >= nDum) begin
                rxByte = (rxByte << lanes) |
                    8'(lanes == 1 ? {3'h0, pinIo[1]} : pinIo & m);
            end
            half();
            sclk <= 1'b0;
        end
        half();
        csN <= 1'b1;
        hostIo <= ~hostIo;
        half();
    endtask : frame
endmodule : wlrc_host_model

// File: tb_wlrc_cmd_decoder.sv
// Self-checking bench for the latch and register decoder
// Assumes the host model and the bound port checker
`timescale 1ns/1ps
`include "wlrc_map.svh"

`define CHK(got, exp) begin \
    nTests++; \
    if ((got) !== (exp)) begin \
        nErrors++; \
        $display("unexpected at %0t: got %h exp %h", $time, got, exp); \
    end \
end

module tb_wlrc_cmd_decoder;
    logic ref_clk, arst_n, swReset, wpN, sclk, csN;
    logic dualProtocolMode, quadProtocolMode, writeInProgressFlag;
    logic crcSuspendFlag, crcAbortFlag, writeLatchBit;
    logic [3:0] hostIo, pinIo, ioOut, ioOe;
    logic [7:0] statusRegOne;
    logic [7:0] ops[6] = '{`OP_RD_SR1, `OP_RD_SR2, `OP_RD_CR1,
        `OP_RD_CR2, `OP_RD_CR4, `OP_RD_CR5};
    logic [7:0] exps[6] = '{8'h00, 8'h03, 8'hAA, 8'h3C, 8'h5A, 8'h01};
    int nErrors = 0;
    int nTests = 0;
    int dummies = 0;

    assign pinIo = (ioOe & ioOut) | (~ioOe & hostIo);

    wlrc_cmd_decoder i_dut (.ref_clk(ref_clk), .arst_n(arst_n),
        .swReset(swReset), .sclk(sclk), .csN(csN), .wpN(wpN),
        .ioIn(pinIo), .ioOut(ioOut), .ioOe(ioOe),
        .dualProtocolMode(dualProtocolMode),
        .quadProtocolMode(quadProtocolMode),
        .writeInProgressFlag(writeInProgressFlag),
        .crcSuspendFlag(crcSuspendFlag), .crcAbortFlag(crcAbortFlag),
        .statusRegOne(statusRegOne), .writeLatchBit(writeLatchBit));

    wlrc_host_model i_host (.ref_clk(ref_clk), .sclk(sclk),
        .csN(csN), .hostIo(hostIo), .pinIo(pinIo));

    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    // ****
    // Helpers
    // ****
    task automatic finishTest();
        $display("comparisons %0d mismatches %0d", nTests, nErrors);
        if (nErrors == 0 && nTests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : finishTest

    task automatic done(input string s);
        $display("%s test finished, mismatches %0d", s, nErrors);
    endtask : done

    // Effects land a few cycles after chip select rises
    task automatic cmd(input logic [47:0] tx, input int n);
        i_host.frame(tx, n, 0, 0);
        repeat (3) @(posedge ref_clk);
    endtask : cmd

    task automatic wen(input logic [47:0] tx, input int n);
        cmd({`OP_SET_LATCH, 40'h0}, 8);
        cmd(tx, n);
    endtask : wen

    task automatic rd(input logic [31:0] h, input int n,
        input logic [7:0] exp);
        i_host.frame({h, 16'h0}, n, dummies, 8);
        repeat (3) @(posedge ref_clk);
        `CHK(i_host.rxByte, exp)
    endtask : rd

    // ****
    // Scenarios
    // ****
    task automatic t_latch();
        `CHK(statusRegOne, 8'h00)
        cmd({`OP_SET_LATCH, 40'h0}, 7);
        `CHK(writeLatchBit, 1'b0)
        cmd({8'hFF, `OP_SET_LATCH, 32'h0}, 16);
        `CHK(writeLatchBit, 1'b0)
        cmd({`OP_SET_LATCH, 40'h0}, 8);
        `CHK(writeLatchBit, 1'b1)
        rd({`OP_RD_SR1, 24'h0}, 8, 8'h02);
        writeInProgressFlag <= 1'b1;
        cmd({`OP_CLR_LATCH, 40'h0}, 8);
        `CHK(writeLatchBit, 1'b1)
        rd({`OP_RD_SR1, 24'h0}, 8, 8'h03);
        writeInProgressFlag <= 1'b0;
        cmd({`OP_CLR_LATCH, 40'h0}, 8);
        `CHK(writeLatchBit, 1'b0)
        done("latch");
    endtask : t_latch

    task automatic t_write_status_cmd();
        cmd({`OP_WR_STATUS, 8'hFC, 32'h0}, 16);
        `CHK(statusRegOne, 8'h00)
        wen({`OP_WR_STATUS, 8'hFF, 32'h0}, 16);
        `CHK(statusRegOne, 8'hFC)
        `CHK(writeLatchBit, 1'b0)
        wpN <= 1'b0;
        wen({`OP_WR_STATUS, 8'h00, 32'h0}, 16);
        `CHK(statusRegOne, 8'hFC)
        wen({`OP_WR_ANY, 24'h07_0000, 16'h0}, 40);
        `CHK(statusRegOne, 8'hFC)
        wpN <= 1'b1;
        wen({`OP_WR_ANY, 24'h07_0000, 8'h84, 8'h00}, 40);
        `CHK(statusRegOne, 8'h84)
        swReset <= 1'b1;
        @(posedge ref_clk);
        swReset <= 1'b0;
        repeat (2) @(posedge ref_clk);
        `CHK(statusRegOne, 8'hFC)
        wen({`OP_WR_STATUS, 8'h00, 32'h0}, 16);
        `CHK(statusRegOne, 8'h00)
        done("status write");
    endtask : t_write_status_cmd

    task automatic t_write_any_reg_cmd();
        wen({`OP_WR_ANY, 24'h00_0006, 8'h01, 8'h00}, 40);
        dummies = 1;
        wen({`OP_WR_ANY, 24'h07_0002, 8'hAA, 8'h55}, 48);
        wen({`OP_WR_ANY, 24'h07_0003, 8'h3C, 8'h00}, 40);
        wen({`OP_WR_ANY, 24'h07_0005, 8'h5A, 8'h00}, 40);
        crcSuspendFlag <= 1'b1;
        crcAbortFlag <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            rd({ops[i], 24'h0}, 8, exps[i]);
        end
        rd({`OP_RD_ANY, 24'h07_0002}, 32, 8'hAA);
        wen({`OP_WR_ANY, 24'h07_0006, 8'h03, 8'h00}, 40);
        dummies = 3;
        rd({`OP_RD_CR5, 24'h0}, 8, 8'h03);
        wen({`OP_WR_ANY, 24'h07_0006, 16'h0}, 40);
        dummies = 0;
        crcSuspendFlag <= 1'b0;
        crcAbortFlag <= 1'b0;
        done("any register");
    endtask : t_write_any_reg_cmd

    task automatic t_lanes();
        for (int k = 1; k < 3; k++) begin
            dualProtocolMode <= (k == 1);
            quadProtocolMode <= (k == 2);
            i_host.lanes = 1 << k;
            repeat (2) @(posedge ref_clk);
            cmd({`OP_SET_LATCH, 40'h0}, 8);
            rd({`OP_RD_SR1, 24'h0}, 8, 8'h02);
            cmd({`OP_CLR_LATCH, 40'h0}, 8);
            `CHK(writeLatchBit, 1'b0)
        end
        done("lanes");
    endtask : t_lanes

    initial begin
        arst_n = 1'b0;
        swReset = 1'b0;
        wpN = 1'b1;
        dualProtocolMode = 1'b0;
        quadProtocolMode = 1'b0;
        writeInProgressFlag = 1'b0;
        crcSuspendFlag = 1'b0;
        crcAbortFlag = 1'b0;
        repeat (4) @(posedge ref_clk);
        arst_n <= 1'b1;
        repeat (6) @(posedge ref_clk);
        t_latch();
        t_write_status_cmd();
        t_write_any_reg_cmd();
        t_lanes();
        finishTest();
    end

    // 44 frames of up to 395 cycles each, with ample margin
    initial begin
        repeat (40000) @(posedge ref_clk);
        nErrors++;
        finishTest();
    end
endmodule : tb_wlrc_cmd_decoder
